// ### design/rbag_pc_update.sv
// Program counter update: sequential advance and relative branch
// Timing at the pins
// step_i marks an instruction retiring; program_counter_o moves on that edge only.
// program_counter_o is the start address of the instruction being retired.
// branch_taken_o pulses for one cycle after each taken step, so the fetch unit can flush.
// Back-to-back steps are allowed; branch_taken_o stays high across taken steps in a row.
// An untaken conditional branch retires like any other instruction.
// A taken relative branch wins over abs_branch_i when both are raised; an untaken one yields to it; no step, no move.
// The sum is kept to 16 bits, so branches across address zero simply wrap.
`timescale 1ns/1ns
`include "rbag_defines.svh"
module rbag_pc_update (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         step_i,
    input  wire logic [`RBAG_LEN_WIDTH-1:0]   instr_len_i,
    input  wire logic                         rel_branch_i,
    input  wire logic                         cond_ok_i,
    input  wire logic                         abs_branch_i,
    input  wire logic [`RBAG_PC_WIDTH-1:0]    abs_target_i,
    input  wire logic [`RBAG_DISP_WIDTH-1:0]  branch_displacement_i,
    output logic      [`RBAG_PC_WIDTH-1:0]    program_counter_o,
    output logic                              branch_taken_o
);
    import rbag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [`RBAG_PC_WIDTH-1:0] program_counter;
    logic [`RBAG_PC_WIDTH-1:0] next_instr;
    logic [`RBAG_PC_WIDTH-1:0] rel_target;
    logic [`RBAG_PC_WIDTH-1:0] next_program_counter;
    logic                      next_taken;
    rbag_mode_t                mode;

    // Address of the following instruction, wrapping at 16 bits
    always_comb begin
        next_instr = program_counter + {{(`RBAG_PC_WIDTH-`RBAG_LEN_WIDTH){1'b0}}, instr_len_i};
    end

    rbag_target_add u_add (
        .next_instr_i (next_instr),
        .disp_i       (branch_displacement_i),
        .target_o     (rel_target)
    );

    // Mode select; an untaken conditional falls through to the abs_branch_i check, then sequential
    always_comb begin
        if (rel_branch_i && cond_ok_i) begin
            mode = RBAG_REL;
        end else if (abs_branch_i) begin
            mode = RBAG_ABS;
        end else begin
            mode = RBAG_SEQ;
        end
    end

    always_comb begin
        case (mode)
            RBAG_REL: next_program_counter = rel_target;
            RBAG_ABS: next_program_counter = abs_target_i;
            RBAG_SEQ: next_program_counter = next_instr;
            default:  next_program_counter = next_instr;
        endcase
        next_taken = (mode != RBAG_SEQ);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter register, only moves on a retired instruction
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            program_counter <= `RBAG_PC_RESET;
        end else if (step_i) begin
            program_counter <= next_program_counter;
        end
    end

    // Taken flag for the fetch unit to flush its prefetch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            branch_taken_o <= 1'b0;
        end else begin
            branch_taken_o <= step_i && next_taken;
        end
    end

    assign program_counter_o = program_counter;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Every step sequence carries !reset_i itself: the disable condition is read
    // after the release edge has updated it, so an attempt begun on that edge
    // would otherwise expect an advance that reset swallowed.

    // Checker helpers, written from the rules rather than taken from the adder
    function automatic logic [`RBAG_PC_WIDTH-1:0] chk_sext(input logic [`RBAG_DISP_WIDTH-1:0] disp);
        chk_sext = {{(`RBAG_PC_WIDTH-`RBAG_DISP_WIDTH){disp[`RBAG_DISP_SIGN_BIT]}}, disp};
    endfunction : chk_sext

    function automatic logic [`RBAG_PC_WIDTH-1:0] chk_advance(input logic [`RBAG_PC_WIDTH-1:0]  pc,
                                                              input logic [`RBAG_LEN_WIDTH-1:0] len);
        chk_advance = pc + {{(`RBAG_PC_WIDTH-`RBAG_LEN_WIDTH){1'b0}}, len};
    endfunction : chk_advance

    // One retired step of each kind, sampled on a single edge
    sequence seq_rel_step;
        !reset_i && step_i && rel_branch_i && cond_ok_i;
    endsequence

    sequence seq_plain_step;
        !reset_i && step_i && !rel_branch_i && !abs_branch_i;
    endsequence

    sequence seq_neg_rel_step;
        !reset_i && step_i && rel_branch_i && cond_ok_i && branch_displacement_i[`RBAG_DISP_SIGN_BIT];
    endsequence

    sequence seq_abs_step;
        !reset_i && step_i && abs_branch_i && !(rel_branch_i && cond_ok_i);
    endsequence

    sequence seq_untaken_rel_step;
        !reset_i && step_i && rel_branch_i && !cond_ok_i && !abs_branch_i;
    endsequence

    // Two plain retires on consecutive edges
    sequence seq_plain_pair;
        seq_plain_step ##1 seq_plain_step;
    endsequence

    // Sequential path
    AST_SEQ_ADVANCE: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_plain_step |=> program_counter == $past(program_counter) + 16'($past(instr_len_i)))
        else $error("sequential advance wrong");

    AST_BACK_TO_BACK: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_plain_pair |=> program_counter == 16'($past(program_counter, 2) + 16'($past(instr_len_i, 2))
            + 16'($past(instr_len_i))))
        else $error("back-to-back advance wrong");

    AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        (!reset_i && !step_i) |=> $stable(program_counter))
        else $error("program counter moved without a step");

    AST_SEQ_NO_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_plain_step |=> !branch_taken_o)
        else $error("taken flag raised on a plain step");

    // Relative path
    AST_REL_TARGET: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_rel_step |=> program_counter == 16'($past(program_counter) + 16'($past(instr_len_i))
            + {{8{$past(branch_displacement_i[7])}}, $past(branch_displacement_i)}))
        else $error("relative target wrong");

    AST_ZERO_DISP: assert property (@(posedge clk_i) disable iff (reset_i)
        (seq_rel_step ##0 (branch_displacement_i == 8'h00)) |=>
            program_counter == chk_advance($past(program_counter), $past(instr_len_i)))
        else $error("zero displacement did not land on the next instruction");

    AST_NEG_DISP: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_neg_rel_step |=>
            16'(program_counter - chk_advance($past(program_counter), $past(instr_len_i)))
            == {8'hff, $past(branch_displacement_i)})
        else $error("negative displacement not applied");

    AST_RANGE: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_rel_step |=> 16'(program_counter - chk_advance($past(program_counter), $past(instr_len_i))
            + 16'h0080) < 16'h0100)
        else $error("branch landed outside the signed displacement range");

    AST_SIGN_EXT: assert property (@(posedge clk_i) disable iff (reset_i)
        (rel_target - next_instr) == {{8{branch_displacement_i[7]}}, branch_displacement_i})
        else $error("sign extension wrong");

    AST_COND_UNTAKEN: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_untaken_rel_step |=>
            program_counter == $past(program_counter) + 16'($past(instr_len_i)) && !branch_taken_o)
        else $error("untaken conditional moved off sequence");

    AST_ABS_OVER_UNTAKEN: assert property (@(posedge clk_i) disable iff (reset_i)
        (seq_abs_step ##0 rel_branch_i) |=> program_counter == $past(abs_target_i) && branch_taken_o)
        else $error("untaken conditional blocked the other branch");

    AST_UPPER_FILL: assert property (@(posedge clk_i) disable iff (reset_i)
        !branch_displacement_i[7] |-> (rel_target - next_instr) < 16'h0080)
        else $error("upper fill wrong for positive displacement");

    AST_NEG_FILL: assert property (@(posedge clk_i) disable iff (reset_i)
        branch_displacement_i[`RBAG_DISP_SIGN_BIT] |-> (rel_target - next_instr) >= 16'hff80)
        else $error("upper fill wrong for negative displacement");

    AST_WRAP_CARRY: assert property (@(posedge clk_i) disable iff (reset_i)
        rel_target == 16'(17'(next_instr) + 17'(chk_sext(branch_displacement_i))))
        else $error("carry out of the target sum not dropped");

    // Other branch kind and the taken flag
    AST_ABS_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_abs_step |=> program_counter == $past(abs_target_i))
        else $error("branch target not loaded");

    AST_TAKEN_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_rel_step |=> branch_taken_o)
        else $error("taken flag missing");

    AST_STEP_ONLY_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        (!reset_i && !step_i) |=> !branch_taken_o)
        else $error("taken flag raised without a step");
endmodule : rbag_pc_update

// ### common/rbag_defines.svh
// Constants for the program counter update block
`ifndef RBAG_DEFINES_SVH
`define RBAG_DEFINES_SVH
`define RBAG_PC_WIDTH      16
`define RBAG_DISP_WIDTH    8
`define RBAG_DISP_SIGN_BIT 7
`define RBAG_LEN_WIDTH     3
`define RBAG_PC_RESET      16'h0000
`define RBAG_DISP_MIN      (-128)
`define RBAG_DISP_MAX      127
`endif

// ### common/rbag_pkg.sv
// Types for the program counter update block
`include "rbag_defines.svh"
package rbag_pkg;
    typedef enum logic [1:0] {
        RBAG_SEQ,
        RBAG_REL,
        RBAG_ABS
    } rbag_mode_t;
    typedef logic [`RBAG_PC_WIDTH-1:0] rbag_addr_t;
endpackage : rbag_pkg

// ### design/rbag_target_add.sv
// Relative target adder with sign extension
`timescale 1ns/1ns
`include "rbag_defines.svh"
module rbag_target_add (
    input  wire logic [`RBAG_PC_WIDTH-1:0]   next_instr_i,
    input  wire logic [`RBAG_DISP_WIDTH-1:0] disp_i,
    output logic      [`RBAG_PC_WIDTH-1:0]   target_o
);
    import rbag_pkg::*;

    logic [`RBAG_PC_WIDTH-1:0] disp_ext;

    // Upper bits copied from the sign bit
    always_comb begin
        disp_ext = {{(`RBAG_PC_WIDTH-`RBAG_DISP_WIDTH){disp_i[`RBAG_DISP_SIGN_BIT]}}, disp_i};
    end

    // Carry out of bit 15 is simply dropped
    always_comb begin
        target_o = next_instr_i + disp_ext;
    end
endmodule : rbag_target_add

// ### tb/rbag_pc_update_tb_top.sv
// Self-checking bench for the program counter update block
`timescale 1ns/1ns
`include "rbag_defines.svh"
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module rbag_pc_update_tb_top;
    import rbag_pkg::*;
    logic                          clk_i = 1'b0;
    logic                          reset_i = 1'b1;
    logic                          step_i = 1'b0;
    logic [`RBAG_LEN_WIDTH-1:0]    instr_len_i = 3'h0;
    logic                          rel_branch_i = 1'b0;
    logic                          cond_ok_i = 1'b0;
    logic                          abs_branch_i = 1'b0;
    logic [`RBAG_PC_WIDTH-1:0]     abs_target_i = 16'h0000;
    logic [`RBAG_DISP_WIDTH-1:0]   branch_displacement_i = 8'h00;
    logic [`RBAG_PC_WIDTH-1:0]     program_counter_o;
    logic                          branch_taken_o;
    int                            n_mismatch = 0;
    int                            tests_run = 0;
    rbag_pc_update dut (.clk_i(clk_i), .reset_i(reset_i), .step_i(step_i), .instr_len_i(instr_len_i),
        .rel_branch_i(rel_branch_i), .cond_ok_i(cond_ok_i), .abs_branch_i(abs_branch_i),
        .abs_target_i(abs_target_i), .branch_displacement_i(branch_displacement_i),
        .program_counter_o(program_counter_o), .branch_taken_o(branch_taken_o));
    // 25 MHz core clock
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    // One retired instruction; step drops at the sampling edge so it is a single retire
    task automatic st(input logic [2:0] len, input logic rel, cond, abs, input logic [15:0] tgt,
                      input logic [7:0] disp, input logic [15:0] exp_pc, input logic exp_tk);
        @(posedge clk_i);
        step_i <= 1'b1;
        instr_len_i <= len;
        rel_branch_i <= rel;
        cond_ok_i <= cond;
        abs_branch_i <= abs;
        abs_target_i <= tgt;
        branch_displacement_i <= disp;
        @(posedge clk_i);
        step_i <= 1'b0;
        #1;
        `CHK(program_counter_o, exp_pc)
        `CHK(branch_taken_o, exp_tk)
    endtask : st
    // Without a step the counter holds, even with branch inputs left asserted
    task automatic idle(input logic [15:0] exp_pc);
        @(posedge clk_i);
        #1;
        `CHK(program_counter_o, exp_pc)
        `CHK(branch_taken_o, 1'b0)
    endtask : idle
    task automatic t_seq();
        st(3'h1, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h00, 16'h0001, 1'b0);
        st(3'h7, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h00, 16'h0008, 1'b0);
        idle(16'h0008);
    endtask : t_seq
    task automatic t_rel();
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'hfe, 16'h0008, 1'b1);
        idle(16'h0008);
        st(3'h2, 1'b1, 1'b0, 1'b0, 16'h0000, 8'h10, 16'h000a, 1'b0);
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h7f, 16'h008b, 1'b1);
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h80, 16'h000d, 1'b1);
        st(3'h3, 1'b0, 1'b0, 1'b1, 16'h1234, 8'h00, 16'h1234, 1'b1);
        st(3'h1, 1'b1, 1'b1, 1'b1, 16'hffff, 8'h05, 16'h123a, 1'b1);
    endtask : t_rel
    // Carry and borrow out of bit 15 must vanish
    task automatic t_wrap();
        st(3'h1, 1'b0, 1'b0, 1'b1, 16'hfff0, 8'h00, 16'hfff0, 1'b1);
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h7f, 16'h0071, 1'b1);
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h80, 16'hfff3, 1'b1);
        st(3'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h00, 16'hfff5, 1'b1);
    endtask : t_wrap
    // Back-to-back retires: step held high over four edges, branches last
    task automatic t_burst();
        @(posedge clk_i);
        step_i <= 1'b1;
        instr_len_i <= 3'h2;
        rel_branch_i <= 1'b0;
        cond_ok_i <= 1'b0;
        abs_branch_i <= 1'b0;
        @(posedge clk_i);
        instr_len_i <= 3'h3;
        #1;
        `CHK(program_counter_o, 16'hfff7)
        `CHK(branch_taken_o, 1'b0)
        @(posedge clk_i);
        instr_len_i <= 3'h1;
        rel_branch_i <= 1'b1;
        cond_ok_i <= 1'b1;
        branch_displacement_i <= 8'h10;
        #1;
        `CHK(program_counter_o, 16'hfffa)
        @(posedge clk_i);
        cond_ok_i <= 1'b0;
        abs_branch_i <= 1'b1;
        abs_target_i <= 16'h4000;
        #1;
        `CHK(program_counter_o, 16'h000b)
        `CHK(branch_taken_o, 1'b1)
        @(posedge clk_i);
        step_i <= 1'b0;
        #1;
        `CHK(program_counter_o, 16'h4000)
        `CHK(branch_taken_o, 1'b1)
        @(posedge clk_i);
        #1;
        `CHK(branch_taken_o, 1'b0)
    endtask : t_burst
    // Mid-run reset with a step held through it; the first step after release counts
    task automatic t_reset();
        @(posedge clk_i);
        reset_i <= 1'b1;
        step_i <= 1'b1;
        instr_len_i <= 3'h4;
        rel_branch_i <= 1'b0;
        abs_branch_i <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(program_counter_o, `RBAG_PC_RESET)
        `CHK(branch_taken_o, 1'b0)
        @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        step_i <= 1'b0;
        #1;
        `CHK(program_counter_o, 16'h0004)
        `CHK(branch_taken_o, 1'b0)
    endtask : t_reset
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK(program_counter_o, 16'h0000)
        t_seq();
        t_rel();
        t_wrap();
        t_burst();
        t_reset();
        end_sim();
    end
endmodule : rbag_pc_update_tb_top
